// >>> logic/uart_regs.vh
// constants for the uart transmit/receive datapath
`ifndef UART_REGS_VH
`define UART_REGS_VH
// ****************************************
// register select codes on the host port
// ****************************************
`define SEL_HOLDING     4'h0
`define SEL_INT_ENABLE  4'h1
`define SEL_INT_STATUS  4'h2
`define SEL_FIFO_CTRL   4'h2
`define SEL_LINE_CTRL   4'h3
`define SEL_MODEM_CTRL  4'h4
`define SEL_LINE_STATUS 4'h5
`define SEL_TX_DIV_LOW  4'h8
`define SEL_TX_DIV_HIGH 4'h9
`define SEL_TX_DIV_FRAC 4'hA
`define SEL_RX_DIV_LOW  4'hC
`define SEL_RX_DIV_HIGH 4'hD
`define SEL_RX_DIV_FRAC 4'hE
// ****************************************
// reset values
// ****************************************
`define RST_DIV_LOW     8'h01
`define RST_DIV_HIGH    8'h00
`define RST_DIV_FRAC    8'h00
`define RST_ZERO        8'h00
// ****************************************
// field positions
// ****************************************
`define FCR_ENABLE      0
`define FCR_RX_FLUSH    1
`define FCR_TX_FLUSH    2
`define IER_RX_DATA     0
`define IER_TX_EMPTY    1
`define MCR_PRESCALE    7
`define LCR_STOP2       2
`define LCR_PARITY_EN   3
`define LCR_PARITY_EVEN 4
`define LSR_DATA_READY  0
`define LSR_OVERRUN     1
`define LSR_THR_EMPTY   5
`define LSR_TX_EMPTY    6
// ****************************************
// oversampling modes and interrupt codes
// ****************************************
`define MODE_16X        2'b00
`define MODE_8X         2'b01
`define MODE_4X         2'b10
`define ISR_NONE        8'h01
`define ISR_TX_EMPTY    8'h02
`define ISR_RX_DATA     8'h04
`define ISR_RX_TIMEOUT  8'h0C
// ****************************************
// receive trigger levels, timeout and fifo depth
// ****************************************
`define TRIG_LVL0       8'h08
`define TRIG_LVL1       8'h10
`define TRIG_LVL2       8'h38
`define TRIG_LVL3       8'h3C
`define TIMEOUT_WORDS   4
`define TIMEOUT_BITS    12
`define FIFO_DEPTH      8'h80
`endif

// >>> logic/baud_gen.v
// fractional baud rate generator giving the sampling clock tick
`timescale 1ns/1ns
module baud_gen (
  input  wire        clk,
  input  wire        nrst,
  input  wire        presc4,   // divide input clock by 4 first
  input  wire [15:0] div_int,  // integer divisor
  input  wire [3:0]  div_frac, // sixteenths
  output reg         tick      // one-cycle sampling clock pulse
);
  reg  [1:0]  pre_q;            // prescaler count
  reg  [16:0] cnt_q;            // prescaled clocks in this period
  reg  [3:0]  acc_q;            // fraction accumulator
  wire        pre_en;
  wire [4:0]  sum;
  wire [16:0] base;
  wire [16:0] limit;
  assign pre_en = ~presc4 | (pre_q == 2'h3);
  assign sum    = {1'b0, acc_q} + {1'b0, div_frac};
  assign base   = (div_int == 16'h0000) ? 17'h00001 : {1'b0, div_int};
  // carry of the accumulator stretches this period by one prescaled clock (four input clocks with presc4)
  assign limit  = base + {16'h0000, sum[4]};
  // ****************************************
  // prescaler and divider
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_q <= 2'h0;
      cnt_q <= 17'h00000;
      acc_q <= 4'h0;
      tick  <= 1'b0;
    end
    else
    begin
      pre_q <= pre_q + 2'h1;  // free running divide by 4
      tick  <= 1'b0;
      if (pre_en)
      begin
        if (cnt_q >= limit - 17'h00001)
        begin
          cnt_q <= 17'h00000;
          acc_q <= sum[3:0];  // average period is integer plus sixteenths
          tick  <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 17'h00001;
      end
    end
  end
endmodule

// >>> logic/sync_fifo.v
// 128-entry synchronous fifo with head presented combinationally
`timescale 1ns/1ns
`include "uart_regs.vh"
module sync_fifo #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire         flush,  // empty the fifo
  input  wire         push,   // store din
  input  wire [W-1:0] din,
  input  wire         pop,    // drop the head
  output wire [W-1:0] dout,   // oldest entry
  output reg  [7:0]   count,  // entries held
  output wire         empty,
  output wire         full
);
  reg  [W-1:0] mem [0:127];   // storage
  reg  [6:0]   wr_q;          // write pointer
  reg  [6:0]   rd_q;          // read pointer
  wire         do_push;
  wire         do_pop;
  assign empty   = (count == 8'h00);
  assign full    = (count == `FIFO_DEPTH);
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign dout    = mem[rd_q];
  // storage write
  always @(posedge clk)
  begin
    if (do_push)
      mem[wr_q] <= din;
  end
  // ****************************************
  // pointers and count
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q  <= 7'h00;
      rd_q  <= 7'h00;
      count <= 8'h00;
    end
    else if (flush)
    begin
      wr_q  <= 7'h00;
      rd_q  <= 7'h00;
      count <= 8'h00;
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + 7'h01;
      if (do_pop)
        rd_q <= rd_q + 7'h01;
      count <= count + {7'h00, do_push} - {7'h00, do_pop};
    end
  end
endmodule

// >>> logic/uart_core.v
// uart transmit and receive datapath with independent baud generators
`timescale 1ns/1ns
`include "uart_regs.vh"
module uart_core (
  input  wire       clk,
  input  wire       nrst,
  input  wire       reg_wr,         // host write strobe
  input  wire       reg_rd,         // host read strobe
  input  wire [3:0] reg_sel,        // register select
  input  wire [7:0] reg_wdata,      // host write data
  output reg  [7:0] reg_rdata,      // host read data
  input  wire       rx_in,          // serial receive line
  output reg        tx_out,         // serial transmit line
  output wire       int_pending     // an interrupt is pending
);
  // ****************************************
  // states and helpers
  // ****************************************
  localparam S_IDLE  = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA  = 3'd2;
  localparam S_PAR   = 3'd3;
  localparam S_STOP  = 3'd4;
  localparam S_STOP2 = 3'd5;
  // sampling ticks per bit for a mode field
  function [4:0] bit_ticks;
    input [1:0] m;
    begin
      case (m)
        `MODE_8X: bit_ticks = 5'd8;
        `MODE_4X: bit_ticks = 5'd4;
        default:  bit_ticks = 5'd16;
      endcase
    end
  endfunction
  // parity over the active word bits
  function par_of;
    input [7:0] d;
    input [1:0] wl;
    input       even;
    reg   [7:0] m;
    begin
      m      = d & (8'hFF >> (2'd3 - wl));
      par_of = even ? ^m : ~^m;
    end
  endfunction
  // ****************************************
  // control registers
  // ****************************************
  reg  [7:0] ier_q;                 // interrupt_enable
  reg  [7:0] fcr_q;                 // fifo_control
  reg  [7:0] lcr_q;                 // line_control
  reg  [7:0] mcr_q;                 // modem_control
  reg  [7:0] tdl_q, tdm_q, tdd_q;   // transmit divisor
  reg  [7:0] rdl_q, rdm_q, rdd_q;   // receive divisor
  wire       fifo_en = fcr_q[`FCR_ENABLE];
  wire       wr_hold = reg_wr & (reg_sel == `SEL_HOLDING);
  wire       wr_fcr  = reg_wr & (reg_sel == `SEL_FIFO_CTRL);
  wire       rd_hold = reg_rd & (reg_sel == `SEL_HOLDING);
  wire       rd_lsr  = reg_rd & (reg_sel == `SEL_LINE_STATUS);
  // register writes
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ier_q <= `RST_ZERO;
      fcr_q <= `RST_ZERO;
      lcr_q <= `RST_ZERO;
      mcr_q <= `RST_ZERO;
      tdl_q <= `RST_DIV_LOW;
      tdm_q <= `RST_DIV_HIGH;
      tdd_q <= `RST_DIV_FRAC;
      rdl_q <= `RST_DIV_LOW;
      rdm_q <= `RST_DIV_HIGH;
      rdd_q <= `RST_DIV_FRAC;
    end
    else if (reg_wr)
    begin
      case (reg_sel)
        `SEL_INT_ENABLE:  ier_q <= reg_wdata;
        `SEL_FIFO_CTRL:   fcr_q <= reg_wdata & 8'hF9;  // flush bits self clear
        `SEL_LINE_CTRL:   lcr_q <= reg_wdata;
        `SEL_MODEM_CTRL:  mcr_q <= reg_wdata;
        `SEL_TX_DIV_LOW:  tdl_q <= reg_wdata;
        `SEL_TX_DIV_HIGH: tdm_q <= reg_wdata;
        `SEL_TX_DIV_FRAC: tdd_q <= reg_wdata;
        `SEL_RX_DIV_LOW:  rdl_q <= reg_wdata;
        `SEL_RX_DIV_HIGH: rdm_q <= reg_wdata;
        `SEL_RX_DIV_FRAC: rdd_q <= reg_wdata;
        default:          ;
      endcase
    end
  end
  // fifos flush on request or when fifo mode changes
  wire mode_chg = wr_fcr & (reg_wdata[`FCR_ENABLE] != fifo_en);
  wire tx_flush = wr_fcr & (reg_wdata[`FCR_TX_FLUSH] | mode_chg);
  wire rx_flush = wr_fcr & (reg_wdata[`FCR_RX_FLUSH] | mode_chg);
  // ****************************************
  // baud generators, one per direction
  // ****************************************
  wire tx_tick;
  wire rx_tick;
  // transmit generator
  baud_gen u_tx_brg (
    .clk      (clk),
    .nrst     (nrst),
    .presc4   (mcr_q[`MCR_PRESCALE]),
    .div_int  ({tdm_q, tdl_q}),
    .div_frac (tdd_q[3:0]),
    .tick     (tx_tick)
  );
  // receive generator
  baud_gen u_rx_brg (
    .clk      (clk),
    .nrst     (nrst),
    .presc4   (mcr_q[`MCR_PRESCALE]),
    .div_int  ({rdm_q, rdl_q}),
    .div_frac (rdd_q[3:0]),
    .tick     (rx_tick)
  );
  // ****************************************
  // transmit path
  // ****************************************
  wire [7:0] txf_dout;
  wire [7:0] txf_cnt;
  wire       txf_empty;
  wire       txf_full;
  reg        tx_pop;
  // non-fifo mode holds a single byte
  wire       tx_room = fifo_en ? ~txf_full : txf_empty;
  // holding write stores byte, pointer advances
  sync_fifo #(.W(8)) u_tx_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .flush (tx_flush),
    .push  (wr_hold & tx_room),
    .din   (reg_wdata),
    .pop   (tx_pop),
    .dout  (txf_dout),
    .count (txf_cnt),
    .empty (txf_empty),
    .full  (txf_full)
  );
  reg  [2:0] ts_q;        // transmit state
  reg  [7:0] tsr_q;       // tx_shifter
  reg  [4:0] tcnt_q;      // ticks within bit
  reg  [2:0] tbit_q;      // data bit index
  reg        tpar_q;      // parity to send
  wire [4:0] t_tpb   = bit_ticks(tdd_q[5:4]);
  wire       t_end   = tx_tick & (tcnt_q == t_tpb - 5'd1);
  wire [2:0] t_last  = {1'b1, lcr_q[1:0]};
  // transmit sequencer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ts_q   <= S_IDLE;
      tsr_q  <= 8'h00;
      tcnt_q <= 5'd0;
      tbit_q <= 3'd0;
      tpar_q <= 1'b0;
      tx_out <= 1'b1;
      tx_pop <= 1'b0;
    end
    else
    begin
      tx_pop <= 1'b0;
      if (tx_tick)
        tcnt_q <= t_end ? 5'd0 : tcnt_q + 5'd1;
      case (ts_q)
        S_IDLE:
        begin
          tx_out <= 1'b1;
          if (~txf_empty & ~tx_pop & tx_tick)
          begin
            // byte moves into shifter, fifo head is popped on the next cycle
            tsr_q  <= txf_dout;
            tpar_q <= par_of(txf_dout, lcr_q[1:0], lcr_q[`LCR_PARITY_EVEN]);
            tx_pop <= 1'b1;
            tcnt_q <= 5'd0;  // the load tick opens the start bit
            tx_out <= 1'b0;  // start bit
            ts_q   <= S_START;
          end
        end
        S_START:
          if (t_end)
          begin
            tx_out <= tsr_q[0];  // bit 0 first
            tsr_q  <= tsr_q >> 1;
            tbit_q <= 3'd0;
            ts_q   <= S_DATA;
          end
        S_DATA:
          if (t_end)
          begin
            if (tbit_q == t_last)
            begin
              // word length is 5 plus the field
              tbit_q <= 3'd0;
              if (lcr_q[`LCR_PARITY_EN])
              begin
                tx_out <= tpar_q;
                ts_q   <= S_PAR;
              end
              else
              begin
                tx_out <= 1'b1;
                ts_q   <= S_STOP;
              end
            end
            else
            begin
              tx_out <= tsr_q[0];
              tsr_q  <= tsr_q >> 1;
              tbit_q <= tbit_q + 3'd1;
            end
          end
        S_PAR:
          if (t_end)
          begin
            tx_out <= 1'b1;
            ts_q   <= S_STOP;
          end
        S_STOP:
          if (t_end)
            ts_q <= lcr_q[`LCR_STOP2] ? S_STOP2 : S_IDLE;
        S_STOP2:
          if (t_end)
            ts_q <= S_IDLE;
        default:
          ts_q <= S_IDLE;
      endcase
    end
  end
  // holding empty and transmitter empty flags
  wire thr_empty = txf_empty;
  wire tx_empty  = txf_empty & (ts_q == S_IDLE);
  // ****************************************
  // receive path
  // ****************************************
  reg  [2:0]  rs_q;       // receive state
  reg  [7:0]  rsr_q;      // rx_shifter
  reg  [4:0]  rcnt_q;     // ticks within bit
  reg  [2:0]  rbit_q;     // data bit index
  reg         rline_q;    // previous line level
  reg         rpe_q;      // parity mismatch seen
  reg         rpush_q;    // character complete
  reg  [10:0] rword_q;    // character with tags
  wire [4:0]  r_tpb  = bit_ticks(rdd_q[5:4]);
  wire        r_half = rx_tick & (rcnt_q == (r_tpb >> 1) - 5'd1);
  wire        r_full = rx_tick & (rcnt_q == r_tpb - 5'd1);
  wire [7:0]  r_data = rsr_q >> (2'd3 - lcr_q[1:0]);
  // receive sequencer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rs_q    <= S_IDLE;
      rsr_q   <= 8'h00;
      rcnt_q  <= 5'd0;
      rbit_q  <= 3'd0;
      rline_q <= 1'b1;
      rpe_q   <= 1'b0;
      rpush_q <= 1'b0;
      rword_q <= 11'h000;
    end
    else
    begin
      rline_q <= rx_in;
      rpush_q <= 1'b0;
      if (rx_tick)
        rcnt_q <= rcnt_q + 5'd1;
      case (rs_q)
        S_IDLE:
          if (rline_q & ~rx_in)
          begin
            // falling edge starts the counter
            rcnt_q <= 5'd0;
            rs_q   <= S_START;
          end
        S_START:
          if (r_half)
          begin
            rcnt_q <= 5'd0;
            rbit_q <= 3'd0;
            rpe_q  <= 1'b0;
            rs_q   <= rx_in ? S_IDLE : S_DATA;  // false start dropped
          end
        S_DATA:
          if (r_full)
          begin
            // one bit time after previous sample
            rcnt_q <= 5'd0;
            rsr_q  <= {rx_in, rsr_q[7:1]};
            rbit_q <= rbit_q + 3'd1;
            if (rbit_q == {1'b1, lcr_q[1:0]})
              rs_q <= lcr_q[`LCR_PARITY_EN] ? S_PAR : S_STOP;
          end
        S_PAR:
          if (r_full)
          begin
            rcnt_q <= 5'd0;
            // parity mismatch tag
            rpe_q  <= rx_in != par_of(r_data, lcr_q[1:0], lcr_q[`LCR_PARITY_EVEN]);
            rs_q   <= S_STOP;
          end
        S_STOP:
          if (r_full)
          begin
            // tags: break, framing, parity
            rword_q <= {~rx_in & (r_data == 8'h00), ~rx_in, rpe_q, r_data};
            rpush_q <= 1'b1;
            rs_q    <= S_IDLE;
          end
        default:
          rs_q <= S_IDLE;
      endcase
    end
  end
  wire [10:0] rxf_dout;
  wire [7:0]  rxf_cnt;
  wire        rxf_empty;
  wire        rxf_full;
  wire        rx_room = fifo_en ? ~rxf_full : rxf_empty;
  // 128 by 11 receive fifo, oldest at the head
  sync_fifo #(.W(11)) u_rx_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .flush (rx_flush),
    .push  (rpush_q & rx_room),
    .din   (rword_q),
    .pop   (rd_hold),  // read advances pointer
    .dout  (rxf_dout),
    .count (rxf_cnt),
    .empty (rxf_empty),
    .full  (rxf_full)
  );
  // ****************************************
  // overrun, timeout and status
  // ****************************************
  reg        ovr_q;    // character lost to a full fifo, or to a held byte in non-fifo mode
  reg        tmo_q;    // receive timeout pending
  reg  [9:0] tocnt_q;  // receive ticks without activity
  wire [4:0] wbits   = {2'b00, lcr_q[1:0]} + 5'd5;
  // four word lengths plus twelve bits, in ticks
  wire [31:0] to_all = (wbits * `TIMEOUT_WORDS + `TIMEOUT_BITS) * r_tpb;
  wire [9:0] to_lim  = to_all[9:0];  // at most 704 ticks, fits ten bits
  // overrun and timeout tracking; overrun set wins over clear, timeout clear wins over set
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovr_q   <= 1'b0;
      tmo_q   <= 1'b0;
      tocnt_q <= 10'd0;
    end
    else
    begin
      if (rpush_q & ~rx_room)
        ovr_q <= 1'b1;
      else if (rd_lsr)
        ovr_q <= 1'b0;
      if (rpush_q | rd_hold | rxf_empty)
        tocnt_q <= 10'd0;  // activity restarts the wait
      else if (rx_tick & (tocnt_q != to_lim))
        tocnt_q <= tocnt_q + 10'd1;
      if (~rxf_empty & (tocnt_q == to_lim) & ~rpush_q & ~rd_hold)
        tmo_q <= 1'b1;
      else if (rd_hold | rxf_empty)
        tmo_q <= 1'b0;
    end
  end
  // trigger level from fifo control bits 7:6, one in non-fifo mode
  reg [7:0] trig;
  always @*
  begin
    case (fcr_q[7:6])
      2'b00:   trig = `TRIG_LVL0;
      2'b01:   trig = `TRIG_LVL1;
      2'b10:   trig = `TRIG_LVL2;
      default: trig = `TRIG_LVL3;
    endcase
    if (!fifo_en)
      trig = 8'h01;
  end
  // line status; tags follow the current head
  wire [2:0] tags = rxf_empty ? 3'b000 : rxf_dout[10:8];
  wire [7:0] line_status  = {1'b0, tx_empty, thr_empty, tags, ovr_q, ~rxf_empty};
  // interrupt status by priority
  reg  [7:0] interrupt_status;
  always @*
  begin
    interrupt_status = `ISR_NONE;
    if (ier_q[`IER_TX_EMPTY] & thr_empty)
      interrupt_status = `ISR_TX_EMPTY;
    if (ier_q[`IER_RX_DATA] & (rxf_cnt >= trig))
      interrupt_status = `ISR_RX_DATA;
    if (ier_q[`IER_RX_DATA] & tmo_q)
      interrupt_status = `ISR_RX_TIMEOUT;
  end
  assign int_pending = ~interrupt_status[0];
  // ****************************************
  // read data
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_sel)
        `SEL_HOLDING:     reg_rdata <= rxf_dout[7:0];
        `SEL_INT_ENABLE:  reg_rdata <= ier_q;
        `SEL_INT_STATUS:  reg_rdata <= interrupt_status;
        `SEL_LINE_CTRL:   reg_rdata <= lcr_q;
        `SEL_MODEM_CTRL:  reg_rdata <= mcr_q;
        `SEL_LINE_STATUS: reg_rdata <= line_status;
        `SEL_TX_DIV_LOW:  reg_rdata <= tdl_q;
        `SEL_TX_DIV_HIGH: reg_rdata <= tdm_q;
        `SEL_TX_DIV_FRAC: reg_rdata <= tdd_q;
        `SEL_RX_DIV_LOW:  reg_rdata <= rdl_q;
        `SEL_RX_DIV_HIGH: reg_rdata <= rdm_q;
        `SEL_RX_DIV_FRAC: reg_rdata <= rdd_q;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> verification/uart_core_checker.sv
// port assertions for the uart datapath
`timescale 1ns/1ns
`include "uart_regs.vh"
module uart_core_checker (
  input wire       clk,
  input wire       nrst,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [3:0] reg_sel,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       rx_in,
  input wire       tx_out,
  input wire       int_pending
);
  reg [1:0] ier_q;   // mirror of enable bits
  reg       div_w_q; // a divisor was written
  reg       wrote_q; // holding was written
  // track host writes
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ier_q <= 2'b00;
      div_w_q <= 1'b0;
      wrote_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_sel == `SEL_INT_ENABLE) ier_q <= reg_wdata[1:0];
      if (reg_sel[3]) div_w_q <= 1'b1;
      if (reg_sel == `SEL_HOLDING) wrote_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_low4; !tx_out [*4]; endsequence
  sequence s_high4; tx_out [*4]; endsequence
  property p_low_run; $fell(tx_out) |-> s_low4; endproperty
  a_low_run: assert property (p_low_run) else $error("tx low run short");
  property p_high_run; $rose(tx_out) |-> s_high4; endproperty
  a_high_run: assert property (p_high_run) else $error("tx high run short");
  property p_idle; !wrote_q |-> tx_out; endproperty
  a_idle: assert property (p_idle) else $error("tx left idle unprompted");
  property p_quiet; ier_q == 2'b00 |-> !int_pending; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt while disabled");
  property p_txdiv; reg_rd && reg_sel == `SEL_TX_DIV_LOW && !div_w_q |=> reg_rdata == 8'h01;
  endproperty
  a_txdiv: assert property (p_txdiv) else $error("tx divisor reset");
  property p_rxdiv; reg_rd && reg_sel == `SEL_RX_DIV_LOW && !div_w_q |=> reg_rdata == 8'h01;
  endproperty
  a_rxdiv: assert property (p_rxdiv) else $error("rx divisor reset");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; reg_rd && reg_sel == 4'h7 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind uart_core uart_core_checker chk_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rx_in(rx_in), .tx_out(tx_out), .int_pending(int_pending));

// >>> verification/uart_remote.sv
// remote uart model on the serial line
`timescale 1ns/1ns
module uart_remote #(
  parameter CPB = 4 // clocks per bit
) (
  input  wire clk,
  input  wire tx_line, // from the block
  output reg  rx_line  // into the block
);
  reg stop_q; // stop level of the last frame seen
  initial rx_line = 1'b1;
  // one 8-bit frame, lsb first, stop level chosen
  task send(input [7:0] d, input stop);
    integer i;
    reg [9:0] f;
  begin
    f = {stop, d, 1'b0};
    for (i = 0; i < 10; i = i + 1)
    begin
      rx_line = f[i];
      repeat (CPB) @(negedge clk);
    end
    rx_line = 1'b1;
  end
  endtask
  // short low pulse, not a start bit
  task glitch;
  begin
    rx_line = 1'b0;
    @(negedge clk);
    rx_line = 1'b1;
  end
  endtask
  // sample a frame at bit centres, away from the launching edge
  task recv(output [7:0] d);
    integer i;
  begin
    while (tx_line !== 1'b0) @(negedge clk);
    repeat (CPB / 2) @(negedge clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      repeat (CPB) @(negedge clk);
      d[i] = tx_line;
    end
    repeat (CPB) @(negedge clk);
    stop_q = tx_line;
  end
  endtask
endmodule

// >>> verification/uart_core_tb.sv
// self-checking bench for the uart datapath
`timescale 1ns/1ns
`include "uart_regs.vh"
module uart_core_tb;
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [3:0] reg_sel = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire       rx_in;
  wire       tx_out;
  wire       int_pending;
  integer    n_mismatch = 0;
  integer    n_tests = 0;
  integer    cyc = 0;
  integer    i;
  reg  [7:0] g1;
  reg  [7:0] g2;
  reg  [7:0] sels [0:5];
  reg  [7:0] exps [0:5];
  always #10 clk = ~clk;
  uart_core dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_in(rx_in),
    .tx_out(tx_out), .int_pending(int_pending));
  uart_remote #(.CPB(4)) remote_u (.clk(clk), .tx_line(tx_out), .rx_line(rx_in));
  task results;
  begin
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch = n_mismatch + 1;
    end
  end
  endtask
  task wr(input [3:0] s, input [7:0] d);
  begin
    @(negedge clk);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [3:0] s);
  begin
    @(negedge clk);
    reg_rd = 1'b1;
    reg_sel = s;
    @(negedge clk);
    reg_rd = 1'b0;
  end
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  initial
  begin
    sels[0] = 8'h08; sels[1] = 8'h09; sels[2] = 8'h0A;
    sels[3] = 8'h0C; sels[4] = 8'h0D; sels[5] = 8'h0E;
    exps[0] = 8'h01; exps[1] = 8'h00; exps[2] = 8'h00;
    exps[3] = 8'h01; exps[4] = 8'h00; exps[5] = 8'h00;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
      rd(sels[i][3:0]);
      chk("divisor", exps[i], reg_rdata);
    end
    rd(`SEL_LINE_STATUS);
    chk("status", 8'h60, reg_rdata);
    rd(4'h7);
    chk("unmapped", 8'h00, reg_rdata);
    wr(`SEL_TX_DIV_FRAC, 8'h20);
    wr(`SEL_RX_DIV_FRAC, 8'h20);
    wr(`SEL_LINE_CTRL, 8'h03);
    fork
      remote_u.recv(g1);
      begin
        wr(`SEL_HOLDING, 8'h81);
        repeat (3) @(negedge clk);
        rd(`SEL_LINE_STATUS);
        chk("lone", 8'h20, reg_rdata & 8'h60);
      end
    join
    chk("tx lone", 8'h81, g1);
    chk("tx lone stop", 8'h01, {7'h00, remote_u.stop_q});
    repeat (10) @(negedge clk);
    rd(`SEL_LINE_STATUS);
    chk("done", 8'h60, reg_rdata & 8'h60);
    wr(`SEL_FIFO_CTRL, 8'h01);
    fork
      begin
        remote_u.recv(g1);
        remote_u.recv(g2);
      end
      begin
        wr(`SEL_HOLDING, 8'h96);
        wr(`SEL_HOLDING, 8'h3B);
        repeat (3) @(negedge clk);
        rd(`SEL_LINE_STATUS);
        chk("queued", 8'h00, reg_rdata & 8'h60);
      end
    join
    chk("tx first", 8'h96, g1);
    chk("tx second", 8'h3B, g2);
    chk("tx second stop", 8'h01, {7'h00, remote_u.stop_q});
    repeat (10) @(negedge clk);
    rd(`SEL_LINE_STATUS);
    chk("drained", 8'h60, reg_rdata & 8'h60);
    remote_u.glitch;
    repeat (20) @(negedge clk);
    rd(`SEL_LINE_STATUS);
    chk("false start", 8'h00, reg_rdata & 8'h01);
    remote_u.send(8'hA5, 1'b1);
    remote_u.send(8'h3C, 1'b0);
    repeat (10) @(negedge clk);
    rd(`SEL_LINE_STATUS);
    chk("rx good tags", 8'h01, reg_rdata & 8'h1D);
    wr(`SEL_INT_ENABLE, 8'h02);
    chk("tx irq pin", 8'h01, {7'h00, int_pending});
    rd(`SEL_INT_STATUS);
    chk("tx irq code", `ISR_TX_EMPTY, reg_rdata);
    wr(`SEL_INT_ENABLE, 8'h01);
    rd(`SEL_INT_STATUS);
    chk("no timeout yet", `ISR_NONE, reg_rdata);
    repeat (180) @(negedge clk);
    rd(`SEL_INT_STATUS);
    chk("rx timeout", `ISR_RX_TIMEOUT, reg_rdata);
    chk("rx irq pin", 8'h01, {7'h00, int_pending});
    rd(`SEL_HOLDING);
    chk("rx first", 8'hA5, reg_rdata);
    rd(`SEL_LINE_STATUS);
    chk("rx framing", 8'h09, reg_rdata & 8'h1D);
    rd(`SEL_HOLDING);
    chk("rx second", 8'h3C, reg_rdata);
    results;
  end
endmodule
